// ==== hw/pde_power_down_entry.sv ====
// Power-down entry controller with AXI4-Lite registers and interrupt
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
module pde_power_down_entry #(
  parameter int  WDT_PERIOD = pde_pkg::WDT_PERIOD_DEF,
  localparam int CW         = $clog2(WDT_PERIOD + 1)
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        sleepExec,
  input  wire logic                        wakeIrq,
  input  wire logic                        masterClearIn,
  output logic                             masterClearOut,
  output logic                             masterClearOe,
  input  wire pde_pkg::pde_io_t            ioDrive,
  output var  pde_pkg::pde_io_t            ioPin,
  output var  logic                        oscEnable,
  output var  logic                        resetReq,
  output var  logic                        irq,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [pde_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output var  logic [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [pde_pkg::ADDR_W-1:0]  s_axi_araddr,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output var  logic [31:0]                 s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp
);
  // Master-clear pin synchroniser
  logic mclrMeta;
  logic mclrSync;
  logic mclrLow;

  // Core state
  pde_pkg::pde_state_t  state;
  pde_pkg::pde_state_t  next_state;
  pde_pkg::pde_status_t status;
  pde_pkg::pde_status_t next_status;
  pde_pkg::pde_io_t     next_ioPin;
  logic                 next_oscEnable;
  logic                 next_resetReq;
  logic                 enterSleep;
  logic [pde_pkg::EV_W-1:0] events;

  // Watchdog
  logic [CW-1:0] wdtCount;
  logic          wdtTimeout;

  // Register file and bus
  logic [pde_pkg::CTRL_W-1:0] ctrl;
  logic [pde_pkg::CTRL_W-1:0] next_ctrl;
  logic [pde_pkg::EV_W-1:0]   irqStat;
  logic [pde_pkg::EV_W-1:0]   next_irqStat;
  logic [pde_pkg::EV_W-1:0]   irqEn;
  logic [pde_pkg::EV_W-1:0]   next_irqEn;
  logic [pde_pkg::EV_W-1:0]   irqClr;
  logic                       next_irq;
  logic                       awHeld;
  logic                       next_awHeld;
  logic [pde_pkg::ADDR_W-1:0] awAddr;
  logic [pde_pkg::ADDR_W-1:0] next_awAddr;
  logic                       wHeld;
  logic                       next_wHeld;
  logic [31:0]                wData;
  logic [31:0]                next_wData;
  logic [3:0]                 wStrb;
  logic [3:0]                 next_wStrb;
  logic                       next_bvalid;
  logic [1:0]                 next_bresp;
  logic                       next_rvalid;
  logic [31:0]                next_rdata;
  logic [1:0]                 next_rresp;
  logic                       doWrite;
  logic                       wdtEnable;
  logic                       wakeEnable;

  function automatic logic regMapped(input logic [pde_pkg::ADDR_W-1:0] addr);
    logic [pde_pkg::ADDR_W-1:0] a;
    a = {addr[pde_pkg::ADDR_W-1:2], 2'b00};
    regMapped = (a == pde_pkg::OFS_CTRL) || (a == pde_pkg::OFS_STATUS) ||
                (a == pde_pkg::OFS_IRQ_STAT) || (a == pde_pkg::OFS_IRQ_CLR) ||
                (a == pde_pkg::OFS_IRQ_EN) || (a == pde_pkg::OFS_WDT_CNT);
  endfunction

  function automatic logic isReg(input logic [pde_pkg::ADDR_W-1:0] addr,
                                 input logic [pde_pkg::ADDR_W-1:0] ofs);
    isReg = ({addr[pde_pkg::ADDR_W-1:2], 2'b00} == ofs);
  endfunction

  assign wdtEnable  = ctrl[pde_pkg::CTRL_WDT_EN];
  assign wakeEnable = ctrl[pde_pkg::CTRL_WAKE_EN];

  // Open-drain master clear: the block only ever listens to it
  assign masterClearOut = 1'b0;
  assign masterClearOe  = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mclrMeta <= 1'b1;
      mclrSync <= 1'b1;
    end else begin
      mclrMeta <= masterClearIn;
      mclrSync <= mclrMeta;
    end
  end
  // Board keeps the pin high while asleep; a low is a genuine reset
  assign mclrLow = !mclrSync;

  pde_watchdog #(
    .PERIOD (WDT_PERIOD)
  ) u_watchdog (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (wdtEnable),
    .clear   (enterSleep),
    .count   (wdtCount),
    .timeout (wdtTimeout)
  );

  // Time-out and master clear outrank the instruction in the same cycle
  assign enterSleep = (state == pde_pkg::PDE_RUN) && sleepExec && !wdtTimeout && !mclrLow;

  always_comb begin
    next_state     = state;
    next_status    = status;
    next_ioPin     = ioPin;
    next_oscEnable = oscEnable;
    next_resetReq  = wdtTimeout || mclrLow;
    events         = '0;
    case (state)
      pde_pkg::PDE_RUN: begin
        next_ioPin = ioDrive;
        if (wdtTimeout) begin
          next_status.timeoutFlag = 1'b0;
          events[pde_pkg::EV_WDT] = 1'b1;
        end else if (enterSleep) begin
          next_state                = pde_pkg::PDE_SLEEP;
          next_status.powerDownFlag = 1'b0;
          next_status.timeoutFlag   = 1'b1;
          next_oscEnable            = 1'b0;
          events[pde_pkg::EV_SLEEP] = 1'b1;
        end
      end
      pde_pkg::PDE_SLEEP: begin
        // Pins left untouched here hold the drive latched at entry
        if (wdtTimeout || mclrLow || (wakeIrq && wakeEnable)) begin
          next_state               = pde_pkg::PDE_RUN;
          next_oscEnable           = 1'b1;
          events[pde_pkg::EV_WAKE] = 1'b1;
          if (wdtTimeout) begin
            next_status.timeoutFlag = 1'b0;
            events[pde_pkg::EV_WDT] = 1'b1;
          end
        end
      end
      default: begin
        next_state     = pde_pkg::PDE_RUN;
        next_oscEnable = 1'b1;
      end
    endcase
    next_status.asleep = (next_state == pde_pkg::PDE_SLEEP);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state                <= pde_pkg::PDE_RUN;
      status.asleep        <= 1'b0;
      status.timeoutFlag   <= pde_pkg::TO_FLAG_RST;
      status.powerDownFlag <= pde_pkg::PD_FLAG_RST;
      ioPin                <= '0;
      oscEnable            <= 1'b1;
      resetReq             <= 1'b0;
    end else begin
      state     <= next_state;
      status    <= next_status;
      ioPin     <= next_ioPin;
      oscEnable <= next_oscEnable;
      resetReq  <= next_resetReq;
    end
  end

  // AXI4-Lite slave, one write and one read in flight
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_ctrl   = ctrl;
    next_irqEn  = irqEn;
    irqClr      = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = regMapped(awAddr) ? pde_pkg::RESP_OKAY : pde_pkg::RESP_SLVERR;
      if (wStrb[0]) begin
        if (isReg(awAddr, pde_pkg::OFS_CTRL)) begin
          next_ctrl = wData[pde_pkg::CTRL_W-1:0];
        end
        if (isReg(awAddr, pde_pkg::OFS_IRQ_EN)) begin
          next_irqEn = wData[pde_pkg::EV_W-1:0];
        end
        if (isReg(awAddr, pde_pkg::OFS_IRQ_CLR)) begin
          irqClr = wData[pde_pkg::EV_W-1:0];
        end
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // New events win over a clear in the same cycle
    next_irqStat = (irqStat & ~irqClr) | events;
    next_irq     = |(next_irqStat & next_irqEn);
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = regMapped(s_axi_araddr) ? pde_pkg::RESP_OKAY : pde_pkg::RESP_SLVERR;
      next_rdata  = '0;
      if (isReg(s_axi_araddr, pde_pkg::OFS_CTRL)) begin
        next_rdata = 32'(ctrl);
      end else if (isReg(s_axi_araddr, pde_pkg::OFS_STATUS)) begin
        next_rdata = 32'(status);
      end else if (isReg(s_axi_araddr, pde_pkg::OFS_IRQ_STAT)) begin
        next_rdata = 32'(irqStat);
      end else if (isReg(s_axi_araddr, pde_pkg::OFS_IRQ_EN)) begin
        next_rdata = 32'(irqEn);
      end else if (isReg(s_axi_araddr, pde_pkg::OFS_WDT_CNT)) begin
        next_rdata = 32'(wdtCount);
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld       <= 1'b0;
      awAddr       <= '0;
      wHeld        <= 1'b0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pde_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pde_pkg::RESP_OKAY;
      ctrl         <= pde_pkg::CTRL_RST;
      irqEn        <= pde_pkg::EV_RST;
      irqStat      <= pde_pkg::EV_RST;
      irq          <= 1'b0;
    end else begin
      awHeld       <= next_awHeld;
      awAddr       <= next_awAddr;
      wHeld        <= next_wHeld;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      ctrl         <= next_ctrl;
      irqEn        <= next_irqEn;
      irqStat      <= next_irqStat;
      irq          <= next_irq;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_enter;
    enterSleep;
  endsequence

  sequence s_asleep_wdt;
    (state == pde_pkg::PDE_SLEEP) && wdtEnable;
  endsequence

  chk_sleep_entry: assert property (s_enter |=> state == pde_pkg::PDE_SLEEP)
    else $error("instruction did not enter power-down");
  chk_no_other_entry: assert property ((state == pde_pkg::PDE_RUN && !sleepExec)
      |=> state == pde_pkg::PDE_RUN)
    else $error("power-down entered without the instruction");
  chk_wdt_keeps_running: assert property ((s_enter ##0 wdtEnable) ##1 s_asleep_wdt[*3]
      |-> wdtCount == CW'(2))
    else $error("watchdog not cleared or not running in power-down");
  chk_flags_entry: assert property (s_enter |=> !status.powerDownFlag && status.timeoutFlag)
    else $error("status flags wrong after entry");
  chk_osc_off: assert property (s_enter |=> !oscEnable [*2] or
      (!oscEnable ##1 state == pde_pkg::PDE_RUN))
    else $error("oscillator driver not off in power-down");
  chk_io_frozen: assert property ((s_enter ##1 state == pde_pkg::PDE_SLEEP)
      |-> ioPin == $past(ioDrive))
    else $error("port drive changed in power-down");
  chk_wdt_reset_pin: assert property (wdtTimeout |=> resetReq && !masterClearOe)
    else $error("watchdog reset drove master clear");
  chk_wake_irq: assert property ((state == pde_pkg::PDE_SLEEP && wakeIrq && wakeEnable)
      |=> state == pde_pkg::PDE_RUN && oscEnable)
    else $error("enabled wake-up did not end power-down");
  chk_wake_wdt: assert property ((state == pde_pkg::PDE_SLEEP && wdtTimeout)
      |=> state == pde_pkg::PDE_RUN && !status.timeoutFlag && irqStat[pde_pkg::EV_WAKE])
    else $error("watchdog time-out did not wake the device");
endmodule
`default_nettype wire

// ==== hw/pde_pkg.sv ====
// Constants and types shared by the power-down entry block
`default_nettype none
package pde_pkg;
  localparam int ADDR_W = 8;
  localparam int IO_W   = 16;

  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_WDT_CNT  = 8'h14;

  localparam int CTRL_WDT_EN  = 0;
  localparam int CTRL_WAKE_EN = 1;
  localparam int CTRL_W       = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_WDT   = 2;
  localparam int EV_W     = 3;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;

  localparam logic PD_FLAG_RST = 1'b1;
  localparam logic TO_FLAG_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int WDT_PERIOD_DEF = 1000;
  localparam int WDT_PERIOD_MIN = 4;

  typedef struct packed {
    logic [IO_W-1:0] level;
    logic [IO_W-1:0] oe;
  } pde_io_t;

  typedef struct packed {
    logic asleep;
    logic timeoutFlag;
    logic powerDownFlag;
  } pde_status_t;

  typedef enum logic {
    PDE_RUN,
    PDE_SLEEP
  } pde_state_t;
endpackage
`default_nettype wire

// ==== hw/pde_watchdog.sv ====
// Free-running watchdog counter with clear and time-out pulse
`default_nettype none
module pde_watchdog #(
  parameter int  PERIOD = pde_pkg::WDT_PERIOD_DEF,
  localparam int CW     = $clog2(PERIOD + 1)
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic          clear,
  output var  logic [CW-1:0] count,
  output var  logic          timeout
);
  if (PERIOD < pde_pkg::WDT_PERIOD_MIN) begin : g_bad_period
    $error("pde_watchdog: PERIOD too small");
  end

  logic [CW-1:0] next_count;
  logic          next_timeout;

  always_comb begin
    next_count   = count;
    next_timeout = 1'b0;
    if (clear || !enable) begin
      next_count = '0;
    end else if (count == CW'(PERIOD - 1)) begin
      next_count   = '0;
      next_timeout = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count   <= '0;
      timeout <= 1'b0;
    end else begin
      count   <= next_count;
      timeout <= next_timeout;
    end
  end
endmodule
`default_nettype wire

// ==== verif/pde_core_model.sv ====
// Core model that executes the power-down instruction and holds master clear
`default_nettype none
module pde_core_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sleepReq,
  input  wire logic [1:0] lag,
  output var  logic       sleepExec,
  output var  logic       masterClearIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pend;
  logic       busy;
  // Board pull-up keeps the pin high, asleep or not
  assign masterClearIn = 1'b1;
  // Lag models a core that reaches the instruction some cycles later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy      <= 1'b0;
      pend      <= 2'h0;
      sleepExec <= 1'b0;
    end else begin
      sleepExec <= 1'b0;
      if (sleepReq && !busy) begin
        busy <= 1'b1;
        pend <= lag;
      end else if (busy && pend == 2'h0) begin
        sleepExec <= 1'b1;
        busy      <= 1'b0;
      end else if (busy) begin
        pend <= pend - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/pde_power_down_entry_tb.sv ====
// Self-checking bench for the power-down entry controller
`default_nettype none
module pde_power_down_entry_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 32;
  localparam logic [7:0] A_CTRL = pde_pkg::OFS_CTRL;
  localparam logic [7:0] A_STAT = pde_pkg::OFS_STATUS;
  localparam logic [7:0] A_IST  = pde_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] A_ICLR = pde_pkg::OFS_IRQ_CLR;
  localparam logic [7:0] A_IEN  = pde_pkg::OFS_IRQ_EN;
  localparam logic [1:0] OK     = pde_pkg::RESP_OKAY;
  logic             ref_clk, rst, sleepExec, wakeIrq, masterClearIn, masterClearOut;
  logic             masterClearOe, oscEnable, resetReq, irq, sleepReq, bad;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, lag;
  logic [33:0]      expQ[$];
  pde_pkg::pde_io_t ioDrive, ioPin, held;
  int               failures, nChecks, n;

  pde_power_down_entry #(.WDT_PERIOD(P)) uut (.*);
  pde_core_model core (.ref_clk(ref_clk), .rst(rst), .sleepReq(sleepReq), .lag(lag),
                       .sleepExec(sleepExec), .masterClearIn(masterClearIn));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 100);
    if (t >= 100) failures++;
    s_axi_bready <= 1'b0;
    check({32'h0, s_axi_bresp}, {32'h0, OK});
    tick(1);
  endtask

  // Expected answer is queued; the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    t = 0;
    expQ.push_back({r, d});
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 100);
    if (t >= 100) failures++;
    s_axi_rready <= 1'b0;
    tick(1);
  endtask

  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
  end

  // Returns at the edge where the core's instruction is sampled
  task automatic sleep_now();
    int t;
    t = 0;
    lag      <= 2'($urandom_range(3, 0));
    sleepReq <= 1'b1;
    tick(1);
    sleepReq <= 1'b0;
    while (sleepExec !== 1'b1 && t < 20) begin
      tick(1);
      t++;
    end
    held = ioDrive;
    ioDrive <= pde_pkg::pde_io_t'($urandom);
  endtask

  initial begin
    #(50 * 4000);
    failures++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {wakeIrq, sleepReq, lag} = 4'h0;
    ioDrive = '0;
    failures = 0;
    nChecks = 0;
    void'($urandom(32'h01ff));
    tick(2);
    rst <= 1'b0;
    rd(A_STAT, 32'h3, OK);
    rd(A_CTRL, 32'h0, OK);
    rd(8'h18, 32'h0, pde_pkg::RESP_SLVERR);
    check({33'h0, oscEnable}, 34'h1);
    $display("test reset done");
    // Wake-up enabled: a pending wake request must not start power-down
    wr(A_CTRL, 32'h2);
    for (int i = 0; i < 8; i++) begin
      ioDrive <= pde_pkg::pde_io_t'($urandom);
      wakeIrq <= 1'($urandom);
      tick(2);
      check({2'h0, ioPin}, {2'h0, ioDrive});
      check({33'h0, oscEnable}, 34'h1);
    end
    wakeIrq <= 1'b0;
    $display("test running done");
    sleep_now();
    tick(2);
    check({2'h0, ioPin}, {2'h0, held});
    check({33'h0, oscEnable}, 34'h0);
    rd(A_STAT, 32'h6, OK);
    rd(A_IST, 32'h1, OK);
    check({33'h0, irq}, 34'h0);
    wakeIrq <= 1'b1;
    tick(2);
    check({33'h0, oscEnable}, 34'h1);
    wakeIrq <= 1'b0;
    rd(A_STAT, 32'h2, OK);
    rd(A_IST, 32'h3, OK);
    wr(A_IEN, 32'h2);
    tick(2);
    check({33'h0, irq}, 34'h1);
    wr(A_ICLR, 32'h3);
    tick(2);
    check({33'h0, irq}, 34'h0);
    rd(A_IST, 32'h0, OK);
    $display("test wake done");
    // Count left high on purpose: entry must restart it from zero
    wr(A_IEN, 32'h4);
    wr(A_CTRL, 32'h1);
    wakeIrq <= 1'b1;
    tick(16);
    sleep_now();
    n = 0;
    bad = 1'b0;
    while (resetReq !== 1'b1 && n < 200) begin
      tick(1);
      n++;
      if (n > 1 && resetReq !== 1'b1 && oscEnable !== 1'b0) bad = 1'b1;
    end
    check({33'h0, bad}, 34'h0);
    check({33'h0, n >= P - 2 && n <= P + 3}, 34'h1);
    check({32'h0, masterClearOe, masterClearOut}, 34'h0);
    tick(1);
    check({33'h0, oscEnable}, 34'h1);
    wakeIrq <= 1'b0;
    wr(A_CTRL, 32'h0);
    rd(A_STAT, 32'h0, OK);
    check({33'h0, irq}, 34'h1);
    rd(A_IST, 32'h7, OK);
    $display("test watchdog done");
    give_verdict();
  end
endmodule
`default_nettype wire
